// *** rtl/twp_deglitch.sv ***
// Pin synchroniser and glitch filter for one bus line.
// Assumes an asynchronous pin; idle level of the line is high.
`timescale 1ns/1ns
module twp_deglitch (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic rawIn,
    output logic      filtOut
);
    typedef struct packed {
        logic                      s1;
        logic                      s2;
        logic [twp_pkg::FILT_W-1:0] cnt;
        logic                      level;
    } twp_dg_s;

    localparam logic [twp_pkg::FILT_W-1:0] FILT_LAST = twp_pkg::FILT_W'(twp_pkg::FILT_CYCLES - 1);

    twp_dg_s q;
    twp_dg_s d;

    // New level only after it held for the whole suppression time
    always_comb begin
        d    = q;
        d.s1 = rawIn;
        d.s2 = q.s1;
        if (q.s2 == q.level) begin
            d.cnt = '0;
        end else if (q.cnt == FILT_LAST) begin
            d.level = q.s2;
            d.cnt   = '0;
        end else begin
            d.cnt = q.cnt + twp_pkg::FILT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{s1: 1'b1, s2: 1'b1, cnt: '0, level: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign filtOut = q.level;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_filter_hold: assert property (
        $changed(q.level) |-> ($past(q.s2, 1) == q.level) && ($past(q.s2, 7) == q.level)
    ) else $error("Filter passed a short pulse");
endmodule

// *** rtl/twp_pkg.sv ***
// Constants and types shared by the two-wire potentiometer slave.
// Assumes a 125 MHz system clock; all timing counts derive from it.
package twp_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int NOISE_NS      = 50;
    // Least time, so round up
    localparam int FILT_CYCLES   = (NOISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W        = 3;
    localparam int NS_PER_MS     = 1000000;
    localparam int PROG_TIME_MS  = 5;
    // Longest time, so round down
    localparam int PROG_CYCLES   = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int PWRUP_TIME_MS = 1;
    localparam int PWRUP_CYCLES  = PWRUP_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int CNT_W         = 20;
    // Device type code; value is arbitrary
    localparam logic [3:0] DEV_TYPE     = 4'hA;
    localparam logic [3:0] OPC_RD_WIPER = 4'h9;
    localparam logic [3:0] OPC_WR_WIPER = 4'hA;
    localparam logic [3:0] OPC_RD_DR    = 4'hB;
    localparam logic [3:0] OPC_WR_DR    = 4'hC;
    localparam int OPC_MSB  = 7;
    localparam int OPC_LSB  = 4;
    localparam int RSEL_MSB = 3;
    localparam int RSEL_LSB = 2;
    localparam int POT_BIT  = 0;
    localparam int DATA_W   = 6;
    localparam logic [1:0] BYTE_ADDR  = 2'h0;
    localparam logic [1:0] BYTE_INSTR = 2'h1;
    localparam logic [1:0] BYTE_DATA  = 2'h2;
    localparam logic [1:0] BYTE_EXTRA = 2'h3;
    localparam logic [3:0] LAST_BIT   = 4'h7;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [5:0] NV_RESET   = 6'h00;

    typedef enum logic [2:0] {
        TWP_IDLE = 3'h0,
        TWP_RECV = 3'h1,
        TWP_ACK  = 3'h2,
        TWP_SEND = 3'h3,
        TWP_MACK = 3'h4,
        TWP_WAIT = 3'h5
    } twp_state_e;
endpackage

// *** rtl/twp_slave.sv ***
// Two-wire slave front end of a dual 64-tap potentiometer with stored settings.
// Assumes SCL and SDA straight from pins; SDA pad is open drain outside this block.
`timescale 1ns/1ns
module twp_slave #(
    parameter int PROG_CYCLES  = twp_pkg::PROG_CYCLES,
    parameter int PWRUP_CYCLES = twp_pkg::PWRUP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic       addrPin0,
    input  wire logic       addrPin1,
    input  wire logic       addrPin2,
    input  wire logic       addrPin3,
    input  wire logic       writeProtectN,
    output logic [5:0]      wiperPos0,
    output logic [5:0]      wiperPos1,
    output logic            progBusy,
    output logic            powerUpDone
);
    localparam int CW = twp_pkg::CNT_W;
    localparam int DW = twp_pkg::DATA_W;
    localparam logic [CW-1:0] PROG_LAST  = CW'(PROG_CYCLES - 1);
    localparam logic [CW-1:0] PWRUP_LAST = CW'(PWRUP_CYCLES - 1);
    localparam logic [CW-1:0] CNT_ONE    = CW'(1);

    typedef struct packed {
        twp_pkg::twp_state_e state;
        logic                sclPrev;
        logic                sdaPrev;
        logic [3:0]          addrS1;
        logic [3:0]          addrS2;
        logic                wpS1;
        logic                wpS2;
        logic                wpDropped;
        logic [3:0]          bitCnt;
        logic [1:0]          byteIdx;
        logic                ackPhase;
        logic                ackQ;
        logic                dataOk;
        logic [7:0]          rxShift;
        logic [7:0]          instr;
        logic [7:0]          data;
        logic [7:0]          txByte;
        logic                sdaOe;
        logic                sdaOut;
        logic [1:0][DW-1:0]  wiper;
        logic [1:0][3:0][DW-1:0] nv;
        logic                loadPending;
        logic                busy;
        logic [CW-1:0]       progCnt;
        logic [CW-1:0]       pwrCnt;
        logic                pwrDone;
    } twp_slave_s;

    twp_slave_s  q;
    twp_slave_s  d;
    logic [1:0]  rawPins;
    logic [1:0]  filtPins;
    logic        sclF;
    logic        sdaF;
    logic        sclRise;
    logic        sclFall;
    logic        startDet;
    logic        stopDet;
    logic [3:0]  opc;
    logic        pot;
    logic [1:0]  sel;
    logic        wpOk;
    logic        isRead;
    logic [7:0]  rxFull;
    logic [7:0]  readVal;

    assign rawPins = {sdaIn, sclIn};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            twp_deglitch u_dg (
                .clk     (clk),
                .rstn    (rstn),
                .rawIn   (rawPins[gi]),
                .filtOut (filtPins[gi])
            );
        end
    endgenerate

    assign sclF = filtPins[0];
    assign sdaF = filtPins[1];

    // Clock is only sampled, never driven
    assign sclRise  = sclF & ~q.sclPrev;
    assign sclFall  = ~sclF & q.sclPrev;
    // SDA edge with SCL high both samples
    assign startDet = sclF & q.sclPrev & q.sdaPrev & ~sdaF;
    assign stopDet  = sclF & q.sclPrev & ~q.sdaPrev & sdaF;

    assign opc    = q.instr[twp_pkg::OPC_MSB:twp_pkg::OPC_LSB];
    assign pot    = q.instr[twp_pkg::POT_BIT];
    assign sel    = q.instr[twp_pkg::RSEL_MSB:twp_pkg::RSEL_LSB];
    assign wpOk   = q.wpS2 & ~q.wpDropped;
    assign isRead = (opc == twp_pkg::OPC_RD_WIPER) || (opc == twp_pkg::OPC_RD_DR);

    always_comb begin
        d       = q;
        rxFull  = {q.rxShift[6:0], sdaF};
        readVal = 8'h00;
        if (opc == twp_pkg::OPC_RD_WIPER) begin
            readVal = {2'h0, q.wiper[pot]};
        end else if (opc == twp_pkg::OPC_RD_DR) begin
            readVal = {2'h0, q.nv[pot][sel]};
        end

        d.sclPrev = sclF;
        d.sdaPrev = sdaF;
        d.addrS1  = {addrPin3, addrPin2, addrPin1, addrPin0};
        d.addrS2  = q.addrS1;
        d.wpS1    = writeProtectN;
        d.wpS2    = q.wpS1;
        // Sticky: a drop anywhere in the transfer cancels programming
        if (!q.wpS2) begin
            d.wpDropped = 1'b1;
        end

        // Bus stays deaf until supply has settled
        if (!q.pwrDone) begin
            if (q.pwrCnt == PWRUP_LAST) begin
                d.pwrDone = 1'b1;
            end else begin
                d.pwrCnt = q.pwrCnt + CNT_ONE;
            end
        end

        // Reset cannot load from a signal, so recall runs one cycle later
        if (q.loadPending) begin
            for (int p = 0; p < 2; p++) begin
                d.wiper[p] = q.nv[p][0];
            end
            d.loadPending = 1'b0;
        end

        // Cell is written at the end, so an early power loss keeps the old value
        if (q.busy) begin
            if (q.progCnt == PROG_LAST) begin
                d.busy         = 1'b0;
                d.nv[pot][sel] = q.data[DW-1:0];
            end else begin
                d.progCnt = q.progCnt + CNT_ONE;
            end
        end

        unique case (q.state)
            twp_pkg::TWP_IDLE: begin
                d.sdaOe = 1'b0;
            end
            twp_pkg::TWP_RECV: begin
                if (sclRise) begin
                    d.rxShift = rxFull;
                    d.bitCnt  = q.bitCnt + 4'h1;
                    if (q.bitCnt == twp_pkg::LAST_BIT) begin
                        d.state    = twp_pkg::TWP_ACK;
                        d.ackPhase = 1'b0;
                        unique case (q.byteIdx)
                            twp_pkg::BYTE_ADDR: begin
                                d.ackQ = (rxFull[7:4] == twp_pkg::DEV_TYPE) &&
                                         (rxFull[3:0] == q.addrS2);
                            end
                            twp_pkg::BYTE_INSTR: begin
                                d.instr = rxFull;
                                d.ackQ  = 1'b1;
                            end
                            twp_pkg::BYTE_DATA: begin
                                d.data   = rxFull;
                                d.ackQ   = (opc != twp_pkg::OPC_WR_DR) || (wpOk && q.wpS2);
                                d.dataOk = d.ackQ;
                            end
                            twp_pkg::BYTE_EXTRA: begin
                                d.ackQ = 1'b1;
                            end
                        endcase
                    end
                end
            end
            twp_pkg::TWP_ACK: begin
                if (sclFall) begin
                    if (!q.ackPhase) begin
                        if (q.ackQ) begin
                            d.sdaOe    = 1'b1;
                            d.ackPhase = 1'b1;
                        end else begin
                            d.state = twp_pkg::TWP_WAIT;
                        end
                    end else begin
                        d.sdaOe  = 1'b0;
                        d.bitCnt = 4'h0;
                        if (q.byteIdx == twp_pkg::BYTE_INSTR && isRead) begin
                            d.state  = twp_pkg::TWP_SEND;
                            d.txByte = readVal;
                            d.sdaOe  = ~readVal[7];
                        end else begin
                            d.state = twp_pkg::TWP_RECV;
                            if (q.byteIdx != twp_pkg::BYTE_EXTRA) begin
                                d.byteIdx = q.byteIdx + 2'h1;
                            end
                        end
                    end
                end
            end
            twp_pkg::TWP_SEND: begin
                if (sclRise) begin
                    d.bitCnt = q.bitCnt + 4'h1;
                end
                if (sclFall) begin
                    if (q.bitCnt == twp_pkg::BYTE_BITS) begin
                        d.sdaOe = 1'b0;
                        d.state = twp_pkg::TWP_MACK;
                    end else begin
                        d.sdaOe = ~q.txByte[3'h7 - q.bitCnt[2:0]];
                    end
                end
            end
            twp_pkg::TWP_MACK: begin
                if (sclRise) begin
                    d.bitCnt = 4'h0;
                    d.state  = sdaF ? twp_pkg::TWP_WAIT : twp_pkg::TWP_SEND;
                end
            end
            twp_pkg::TWP_WAIT: begin
                d.sdaOe = 1'b0;
            end
            default: begin
                d.state = twp_pkg::TWP_IDLE;
                d.sdaOe = 1'b0;
            end
        endcase

        if (startDet) begin
            d.sdaOe  = 1'b0;
            d.dataOk = 1'b0;
            // Busy or not yet powered: address goes unanswered
            if (!q.busy && q.pwrDone) begin
                d.state     = twp_pkg::TWP_RECV;
                d.bitCnt    = 4'h0;
                d.byteIdx   = twp_pkg::BYTE_ADDR;
                d.wpDropped = ~q.wpS2;
            end else begin
                d.state = twp_pkg::TWP_IDLE;
            end
        end else if (stopDet) begin
            d.sdaOe  = 1'b0;
            d.state  = twp_pkg::TWP_IDLE;
            d.dataOk = 1'b0;
            if (q.dataOk) begin
                if (opc == twp_pkg::OPC_WR_WIPER) begin
                    d.wiper[pot] = q.data[DW-1:0];
                end
                if (opc == twp_pkg::OPC_WR_DR && wpOk) begin
                    d.busy    = 1'b1;
                    d.progCnt = '0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q             <= '0;
            q.state       <= twp_pkg::TWP_IDLE;
            q.sclPrev     <= 1'b1;
            q.sdaPrev     <= 1'b1;
            q.wpS1        <= 1'b1;
            q.wpS2        <= 1'b1;
            q.nv          <= {8{twp_pkg::NV_RESET}};
            q.loadPending <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sdaOut      = q.sdaOut;
    assign sdaOe       = q.sdaOe;
    assign wiperPos0   = q.wiper[0];
    assign wiperPos1   = q.wiper[1];
    assign progBusy    = q.busy;
    assign powerUpDone = q.pwrDone;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_busy_quiet: assert property (
        q.busy |-> (q.state == twp_pkg::TWP_IDLE) && !q.sdaOe
    ) else $error("Bus active during program cycle");

    a_busy_ignore: assert property (
        (startDet && q.busy) |=> (q.state == twp_pkg::TWP_IDLE) && !q.sdaOe
    ) else $error("START taken while programming");

    a_prog_time: assert property (
        (q.busy && q.progCnt == PROG_LAST) |=> !q.busy && (q.nv[$past(pot)][$past(sel)] == $past(q.data[DW-1:0]))
    ) else $error("Program cycle did not end on time");

    a_wait_start: assert property (
        (q.state == twp_pkg::TWP_IDLE && !startDet) |=> (q.state == twp_pkg::TWP_IDLE) && !q.sdaOe
    ) else $error("Left idle without START");

    a_stop_ends: assert property (
        (stopDet && !startDet) |=> (q.state == twp_pkg::TWP_IDLE) && !q.sdaOe
    ) else $error("STOP did not end the transfer");

    a_addr_match: assert property (
        (q.state == twp_pkg::TWP_ACK && q.byteIdx == twp_pkg::BYTE_ADDR && $rose(q.sdaOe))
        |-> (q.rxShift[7:4] == twp_pkg::DEV_TYPE) && (q.rxShift[3:0] == q.addrS2)
    ) else $error("Acked a foreign address");

    a_addr_silent: assert property (
        (q.state == twp_pkg::TWP_ACK && !q.ackQ && sclFall && !startDet && !stopDet)
        |=> (q.state == twp_pkg::TWP_WAIT) ##1 !q.sdaOe
    ) else $error("No silence after address miss");

    a_prot_nack: assert property (
        (q.state == twp_pkg::TWP_ACK && $past(q.state) == twp_pkg::TWP_RECV && q.byteIdx == twp_pkg::BYTE_DATA
         && opc == twp_pkg::OPC_WR_DR && !$past(q.wpS2)) |-> !q.ackQ
    ) else $error("Protected data byte acked");

    a_wp_block: assert property (
        (stopDet && !q.wpS2) |=> !$rose(q.busy)
    ) else $error("Program started while protected");

    a_wp_abort: assert property (
        (stopDet && q.wpDropped) |=> !$rose(q.busy)
    ) else $error("Program started after protect drop");

    a_mack_stop: assert property (
        (q.state == twp_pkg::TWP_MACK && sclRise && sdaF && !startDet && !stopDet)
        |=> (q.state == twp_pkg::TWP_WAIT) && !q.sdaOe
    ) else $error("Kept sending after master nack");

    a_read_pad: assert property (
        q.state == twp_pkg::TWP_SEND |-> q.txByte[7:6] == 2'h0
    ) else $error("Read byte upper bits not zero");

    a_wiper_load: assert property (
        $fell(q.loadPending) |-> (q.wiper[0] == q.nv[0][0]) && (q.wiper[1] == q.nv[1][0])
    ) else $error("Wiper not recalled at power-up");

    a_wiper_write: assert property (
        (stopDet && !startDet && q.dataOk && opc == twp_pkg::OPC_WR_WIPER)
        |=> (q.wiper[$past(pot)] == $past(q.data[DW-1:0])) && !$rose(q.busy)
    ) else $error("Wiper write not applied at STOP");
endmodule

// *** verif/twp_bus_master.sv ***
// Behavioural two-wire bus master for the potentiometer slave.
// Assumes SDA is resolved by the bench with a pull-up; the bench calls the tasks.
`timescale 1ns/1ns
module twp_bus_master #(
    parameter int T = 64
) (
    output logic      scl,
    output logic      sdaPullLow,
    input  wire logic sdaLine
);
    logic glitch = 1'b0;

    initial begin
        scl        = 1'b1;
        sdaPullLow = 1'b0;
    end

    // SDA moves mid-low only; glitches stay under the filter time
    task automatic bitSlot(input logic b, output logic s);
        sdaPullLow = ~b;
        #(2*T) scl = 1'b1;
        #(2*T) s = sdaLine;
        if (glitch && b) begin
            sdaPullLow = 1'b1;
            #40 sdaPullLow = 1'b0;
            #(2*T-40);
        end else #(2*T);
        scl = 1'b0;
        #T;
        if (glitch) begin
            scl = 1'b1;
            #40 scl = 1'b0;
            #(T-40);
        end else #T;
    endtask

    // Odd offset per START; offsets add up, so every fourth START after a clock-edge wait puts link edges on the clock grid
    task automatic start();
        #3 sdaPullLow = 1'b0;
        #(2*T) scl = 1'b1;
        #(4*T) sdaPullLow = 1'b1;
        #(4*T) scl = 1'b0;
        #(2*T);
    endtask

    task automatic stop();
        sdaPullLow = 1'b1;
        #(2*T) scl = 1'b1;
        #(4*T) sdaPullLow = 1'b0;
        #(4*T);
    endtask

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitSlot(d[i], s);
        bitSlot(1'b1, s);
        ack = ~s;
    endtask

    task automatic recvByte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(1'b1, s);
            d[i] = s;
        end
        bitSlot(~mack, s);
    endtask
endmodule

// *** verif/twp_slave_tb.sv ***
// Self-checking bench for the two-wire potentiometer slave.
// Assumes short program and power-up counts; expectations come from a local model.
`timescale 1ns/1ns
module twp_slave_tb;
    localparam int PROG  = 200;
    localparam int PWRUP = 50;
    logic       clk         = 1'b0;
    logic       rstn        = 1'b0;
    logic       wpN         = 1'b1;
    logic [3:0] addrPins    = 4'h0;
    logic       scl;
    logic       mPull;
    logic       sdaOut;
    logic       sdaOe;
    logic       progBusy;
    logic       powerUpDone;
    logic [5:0] wiperPos0;
    logic [5:0] wiperPos1;
    logic       ack;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] d;
    logic [7:0] aByte;
    int         bad_count   = 0;
    int         check_count = 0;
    int         stored [2][4];
    int         wiper [2];
    wire        sdaLine     = !(mPull || (sdaOe && !sdaOut));

    always #4 clk = ~clk;

    twp_bus_master master (.scl(scl), .sdaPullLow(mPull), .sdaLine(sdaLine));

    twp_slave #(.PROG_CYCLES(PROG), .PWRUP_CYCLES(PWRUP)) uut (
        .clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrPin0(addrPins[0]), .addrPin1(addrPins[1]), .addrPin2(addrPins[2]), .addrPin3(addrPins[3]),
        .writeProtectN(wpN), .wiperPos0(wiperPos0), .wiperPos1(wiperPos1), .progBusy(progBusy),
        .powerUpDone(powerUpDone)
    );

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic sendChk(input logic [7:0] v, input logic exp);
        master.sendByte(v, ack);
        chk("ack", {7'h00, ack}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] ins, input logic [7:0] dat, input logic dAck);
        master.start();
        sendChk(aByte, 1'b1);
        sendChk(ins, 1'b1);
        sendChk(dat, dAck);
        master.stop();
    endtask

    task automatic rd(input logic [7:0] ins, input int exp);
        master.start();
        sendChk(aByte, 1'b1);
        sendChk(ins, 1'b1);
        master.recvByte(1'b1, b1);
        master.recvByte(1'b0, b2);
        master.stop();
        chk("read", b1, exp[7:0]);
        chk("reread", b2, exp[7:0]);
    endtask

    task automatic poll(input logic exp);
        master.start();
        sendChk(aByte, exp);
        master.stop();
    endtask

    // Busy was already up before counting starts, so PROG is a safe bound
    task automatic waitProg();
        for (int n = 0; n < PROG && progBusy === 1'b1; n++) @(negedge clk);
        chk("progBusy", {7'h00, progBusy}, 8'h00);
    endtask

    task automatic wrSetting(input int p, input int r, input logic ok);
        d = 8'($urandom);
        wr({twp_pkg::OPC_WR_DR, 2'(r), 1'b0, 1'(p)}, d, ok);
        if (ok) stored[p][r] = int'(d[5:0]);
    endtask

    initial begin
        void'($urandom(60054));
        foreach (stored[p, r]) stored[p][r] = 0;
        wiper = '{0, 0};
        repeat (8) @(negedge clk);
        rstn     = 1'b1;
        addrPins = 4'($urandom);
        aByte    = {twp_pkg::DEV_TYPE, addrPins};
        for (int n = 0; n < PWRUP + 20 && powerUpDone !== 1'b1; n++) @(negedge clk);
        chk("powerUpDone", {7'h00, powerUpDone}, 8'h01);
        chk("wiperPos0", {2'h0, wiperPos0}, 8'h00);
        $display("test power-up done");

        for (int i = 0; i < 8; i++) begin
            master.start();
            sendChk(aByte ^ (8'h01 << i), 1'b0);
            sendChk(8'($urandom), 1'b0);
            master.stop();
        end
        $display("test address mismatch done");

        // Glitches ride on every bit of the wiper traffic
        master.glitch = 1'b1;
        @(negedge clk) wpN = 1'b0;
        for (int p = 0; p < 2; p++) begin
            d = 8'($urandom);
            wr({twp_pkg::OPC_WR_WIPER, 3'h0, 1'(p)}, d, 1'b1);
            wiper[p] = int'(d[5:0]);
            chk("wiperPos0", {2'h0, wiperPos0}, wiper[0][7:0]);
            chk("wiperPos1", {2'h0, wiperPos1}, wiper[1][7:0]);
            chk("progBusy", {7'h00, progBusy}, 8'h00);
            rd({twp_pkg::OPC_RD_WIPER, 3'h0, 1'(p)}, wiper[p]);
        end
        master.glitch = 1'b0;
        $display("test wiper done");

        @(negedge clk) wpN = 1'b1;
        for (int r = 0; r < 4; r++) begin
            wrSetting(r % 2, r, 1'b1);
            chk("progBusy", {7'h00, progBusy}, 8'h01);
            poll(1'b0);
            waitProg();
            poll(1'b1);
            rd({twp_pkg::OPC_RD_DR, 2'(r), 1'b0, 1'(r % 2)}, stored[r % 2][r]);
        end
        $display("test stored write done");

        @(negedge clk) wpN = 1'b0;
        wrSetting(0, 1, 1'b0);
        chk("progBusy", {7'h00, progBusy}, 8'h00);
        rd({twp_pkg::OPC_RD_DR, 2'h1, 1'b0, 1'b0}, stored[0][1]);
        @(negedge clk) wpN = 1'b1;
        master.start();
        sendChk(aByte, 1'b1);
        @(negedge clk) wpN = 1'b0;
        sendChk({twp_pkg::OPC_WR_DR, 2'h2, 1'b0, 1'b1}, 1'b1);
        @(negedge clk) wpN = 1'b1;
        sendChk(8'h3F, 1'b0);
        master.stop();
        chk("progBusy", {7'h00, progBusy}, 8'h00);
        $display("test protect done");

        wrSetting(1, 3, 1'b1);
        @(negedge clk) wpN = 1'b0;
        waitProg();
        @(negedge clk) wpN = 1'b1;
        rd({twp_pkg::OPC_RD_DR, 2'h3, 1'b0, 1'b1}, stored[1][3]);
        $display("test late protect done");
        test_done();
    end

    initial begin
        #700000;
        bad_count++;
        $display("ERROR watchdog expected finish seen hang");
        test_done();
    end
endmodule
